/* File: rtl/board_irq_status_and_edge_enable.sv */
// Contract
// R01: eight falling-edge enables in bits 7:0, line one at bit 0, reset 0, 31:8 reserved.
// R02: a status bit latches only if its enable was set before the event.
// R03: clearing an enable keeps a latched bit; only acknowledge removes it.
// R04: acknowledge is status write or status read, selected by configuration.
// R05: the interrupt request is high while any main status bit is set.
// R06: bit 31 is a read-only summary of the pin status register.
// R07: bit 30 is a read-only summary of the error status register.
// R08: bit 29 sets on frame timer expiry when enabled, cleared by acknowledge.
// R09: bit 28 sets on a frame trigger event when enabled, cleared by acknowledge.
// R10: bits 24 to 27 set when converters one to four have results readable.
// R11: bits 16 and 17 set when output converters one and two update.
// R12: bit 12 sets on input sequencer count done or sequencer error.
// R13: bits 10:8 flag input buffer end: error, all data, buffer full.
// R14: bit 4 sets on output sequencer count done or sequencer error.
// R15: bit 0 sets when the output sequencer fetched all buffer data.
// R16: eight rising-edge enables laid out like the falling ones, reset 0.
// R17: the interrupt request drops once all main status bits read zero.
// R18: falling edges on enabled pins latch their bit in the pin status register.
`timescale 1ns/100ps
`default_nettype none

module board_irq_status_and_edge_enable
    import irq_status_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // register port
    input wire logic [irq_status_pkg::ADDR_W-1:0] i_addr,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [irq_status_pkg::DATA_W-1:0] i_wdata,
    output logic [irq_status_pkg::DATA_W-1:0] o_rdata,
    output logic o_rvalid,
    // configuration and error status held elsewhere
    input wire logic i_ack_on_read,
    input wire logic [irq_status_pkg::DATA_W-1:0] i_main_irq_en,
    input wire logic [irq_status_pkg::DATA_W-1:0] i_err_irq_status,
    // digital pins, synchronous to i_clk
    input wire logic [irq_status_pkg::PIN_N-1:0] i_pin,
    // event pulses
    input wire logic i_frame_timer_evt,
    input wire logic i_frame_trigger_evt,
    input wire logic [irq_status_pkg::N_INPUT_CONV-1:0] i_input_conv_done,
    input wire logic [irq_status_pkg::N_OUTPUT_CONV-1:0] i_output_conv_done,
    input wire logic i_in_seq_done,
    input wire logic i_in_seq_err,
    input wire logic [irq_status_pkg::N_BUF_TERM-1:0] i_in_seq_buf_term,
    input wire logic i_out_seq_done,
    input wire logic i_out_seq_err,
    input wire logic i_out_seq_buf_done,
    // interrupt request
    output logic o_irq
);
    import irq_status_pkg::*;

    irq_state_t state_ff;
    irq_state_t nxt_state;

    logic [DATA_W-1:0] main_evt;
    logic [DATA_W-1:0] main_set;
    logic [DATA_W-1:0] main_clr;
    logic [DATA_W-1:0] main_view;
    logic [PIN_STATUS_W-1:0] pin_evt;
    logic [PIN_STATUS_W-1:0] pin_set;
    logic [PIN_STATUS_W-1:0] pin_clr;
    logic [PIN_N-1:0] pin_rise;
    logic [PIN_N-1:0] pin_fall;
    logic pin_any;
    logic err_any;
    logic sel_rise_en;
    logic sel_fall_en;
    logic sel_pin_status;
    logic sel_main_status;

    // address decode
    always_comb begin
        sel_rise_en = (i_addr == OFS_PIN_RISE_EN);
        sel_fall_en = (i_addr == OFS_PIN_FALL_EN);
        sel_pin_status = (i_addr == OFS_PIN_IRQ_STATUS);
        sel_main_status = (i_addr == OFS_MAIN_IRQ_STATUS);
    end

    // pin edge detection against the previous sample
    always_comb begin
        pin_rise = i_pin & ~state_ff.pin_prev;
        pin_fall = ~i_pin & state_ff.pin_prev; // [R18]
        pin_evt = PIN_STATUS_RST;
        pin_evt[PIN_RISE_LO +: PIN_N] = pin_rise;
        pin_evt[PIN_FALL_LO +: PIN_N] = pin_fall;
    end

    // pin events gated by enables held before this cycle
    always_comb begin
        pin_set = PIN_STATUS_RST;
        pin_set[PIN_RISE_LO +: PIN_N] = pin_evt[PIN_RISE_LO +: PIN_N] & state_ff.rise_en; // [R16]
        pin_set[PIN_FALL_LO +: PIN_N] = pin_evt[PIN_FALL_LO +: PIN_N] & state_ff.fall_en; // [R18] [R02]
    end

    // summaries
    always_comb begin
        pin_any = |state_ff.pin_status; // [R06]
        err_any = |i_err_irq_status; // [R07]
    end

    // main status event vector
    always_comb begin
        main_evt = ZERO_WORD;
        main_evt[BIT_FRAME_TIMER_IRQ] = i_frame_timer_evt; // [R08]
        main_evt[BIT_FRAME_TRIGGER_IRQ] = i_frame_trigger_evt; // [R09]
        main_evt[BIT_INPUT_CONV_DONE_LO +: N_INPUT_CONV] = i_input_conv_done; // [R10]
        main_evt[BIT_OUTPUT_CONV_DONE_LO +: N_OUTPUT_CONV] = i_output_conv_done; // [R11]
        main_evt[BIT_IN_SEQ_DONE_IRQ] = i_in_seq_done | i_in_seq_err; // [R12]
        main_evt[BIT_IN_SEQ_BUF_TERM_LO +: N_BUF_TERM] = i_in_seq_buf_term; // [R13]
        main_evt[BIT_OUT_SEQ_DONE_IRQ] = i_out_seq_done | i_out_seq_err; // [R14]
        main_evt[BIT_OUT_SEQ_BUF_DONE_IRQ] = i_out_seq_buf_done; // [R15]
    end

    // enable must already be registered when the event arrives
    always_comb begin
        main_set = main_evt & state_ff.main_en & MAIN_RC_MASK; // [R02]
    end

    // readable view of the main status register
    always_comb begin
        main_view = state_ff.main_status & MAIN_RC_MASK;
        main_view[BIT_PIN_IRQ_SUMMARY] = pin_any; // [R06]
        main_view[BIT_ERR_IRQ_SUMMARY] = err_any; // [R07]
    end

    // acknowledge: write-one-to-clear, or clear what a read returned
    always_comb begin
        main_clr = ZERO_WORD;
        pin_clr = PIN_STATUS_RST;
        if (i_ack_on_read) begin
            if (i_rd && sel_main_status) begin
                main_clr = main_view & MAIN_RC_MASK; // [R04]
            end
            if (i_rd && sel_pin_status) begin
                pin_clr = state_ff.pin_status; // [R04]
            end
        end else begin
            if (i_wr && sel_main_status) begin
                main_clr = i_wdata & MAIN_RC_MASK; // [R04]
            end
            if (i_wr && sel_pin_status) begin
                pin_clr = i_wdata[PIN_STATUS_W-1:0]; // [R04]
            end
        end
    end

    // next state
    always_comb begin
        nxt_state = state_ff;
        nxt_state.pin_prev = i_pin;
        nxt_state.main_en = i_main_irq_en;

        // enables are plain storage; they never touch latched status
        if (i_wr && sel_rise_en) begin
            nxt_state.rise_en = i_wdata[PIN_N-1:0]; // [R16]
        end
        if (i_wr && sel_fall_en) begin
            nxt_state.fall_en = i_wdata[PIN_N-1:0]; // [R01]
        end

        // a set in the clearing cycle survives
        nxt_state.pin_status = (state_ff.pin_status & ~pin_clr) | pin_set; // [R03] [R18]
        nxt_state.main_status = (state_ff.main_status & ~main_clr) | main_set; // [R03] [R08]

        // read data, reserved bits zero, unmapped reads zero
        nxt_state.rvalid = i_rd;
        nxt_state.rdata = RDATA_RST;
        if (i_rd) begin
            if (sel_rise_en) begin
                nxt_state.rdata[PIN_N-1:0] = state_ff.rise_en; // [R16]
            end else if (sel_fall_en) begin
                nxt_state.rdata[PIN_N-1:0] = state_ff.fall_en; // [R01]
            end else if (sel_pin_status) begin
                nxt_state.rdata[PIN_STATUS_W-1:0] = state_ff.pin_status;
            end else if (sel_main_status) begin
                nxt_state.rdata = main_view;
            end else begin
                nxt_state.rdata = RDATA_RST;
            end
        end

        // request follows the register contents of the next cycle
        nxt_state.irq = (|nxt_state.main_status) | (|nxt_state.pin_status) | err_any; // [R05] [R17]

        if (i_rst) begin
            nxt_state.rise_en = PIN_EN_RST; // [R16]
            nxt_state.fall_en = PIN_EN_RST; // [R01]
            nxt_state.pin_prev = i_pin;
            nxt_state.pin_status = PIN_STATUS_RST;
            nxt_state.main_en = ZERO_WORD;
            nxt_state.main_status = MAIN_STATUS_RST;
            nxt_state.rdata = RDATA_RST;
            nxt_state.rvalid = 1'b0;
            nxt_state.irq = 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        state_ff <= nxt_state;
    end

    // outputs straight from flops
    always_comb begin
        o_rdata = state_ff.rdata;
        o_rvalid = state_ff.rvalid;
        o_irq = state_ff.irq; // [R05]
    end

endmodule

`default_nettype wire

/* File: rtl/irq_status_pkg.sv */
package irq_status_pkg;

    // register port geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int PIN_N = 8;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_PIN_RISE_EN = 12'h374;
    localparam logic [ADDR_W-1:0] OFS_PIN_FALL_EN = 12'h378;
    localparam logic [ADDR_W-1:0] OFS_PIN_IRQ_STATUS = 12'h37c;
    localparam logic [ADDR_W-1:0] OFS_MAIN_IRQ_STATUS = 12'h384;

    // main status field positions
    localparam int BIT_PIN_IRQ_SUMMARY = 31;
    localparam int BIT_ERR_IRQ_SUMMARY = 30;
    localparam int BIT_FRAME_TIMER_IRQ = 29;
    localparam int BIT_FRAME_TRIGGER_IRQ = 28;
    localparam int BIT_INPUT_CONV_DONE_LO = 24;
    localparam int BIT_OUTPUT_CONV_DONE_LO = 16;
    localparam int BIT_IN_SEQ_DONE_IRQ = 12;
    localparam int BIT_IN_SEQ_BUF_TERM_LO = 8;
    localparam int BIT_OUT_SEQ_DONE_IRQ = 4;
    localparam int BIT_OUT_SEQ_BUF_DONE_IRQ = 0;

    // field widths
    localparam int N_INPUT_CONV = 4;
    localparam int N_OUTPUT_CONV = 2;
    localparam int N_BUF_TERM = 3;

    // pin status layout: rising edges low byte, falling edges next byte
    localparam int PIN_RISE_LO = 0;
    localparam int PIN_FALL_LO = 8;
    localparam int PIN_STATUS_W = 16;

    // clearable bits of the main status register
    localparam logic [DATA_W-1:0] MAIN_RC_MASK = 32'h3f03_1711;

    // reset values
    localparam logic [PIN_N-1:0] PIN_EN_RST = 8'h00;
    localparam logic [PIN_STATUS_W-1:0] PIN_STATUS_RST = 16'h0000;
    localparam logic [DATA_W-1:0] MAIN_STATUS_RST = 32'h0000_0000;
    localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;
    localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

    typedef struct packed {
        logic [PIN_N-1:0] rise_en;
        logic [PIN_N-1:0] fall_en;
        logic [PIN_N-1:0] pin_prev;
        logic [PIN_STATUS_W-1:0] pin_status;
        logic [DATA_W-1:0] main_en;
        logic [DATA_W-1:0] main_status;
        logic [DATA_W-1:0] rdata;
        logic rvalid;
        logic irq;
    } irq_state_t;

endpackage

/* File: tb/irq_props.sv */
`timescale 1ns/100ps
`default_nettype none
module irq_props
    import irq_status_pkg::*;
(
    input wire logic i_clk, i_rst, i_rd, i_wr, i_ack_on_read, o_rvalid, o_irq,
    input wire logic i_frame_timer_evt, i_frame_trigger_evt,
    input wire logic [irq_status_pkg::ADDR_W-1:0] i_addr,
    input wire logic [irq_status_pkg::DATA_W-1:0] o_rdata, i_main_irq_en, i_err_irq_status
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    AST_READ_ANSWER: assert property (i_rd |=> o_rvalid)
        else $error("read not answered");
    AST_NO_STRAY: assert property (!i_rd |=> !o_rvalid)
        else $error("stray read valid");
    AST_FALL_RSVD: assert property (i_rd && i_addr == OFS_PIN_FALL_EN
        |=> o_rdata[31:8] == 24'h0) else $error("falling enable reserved set");
    AST_RISE_RSVD: assert property (i_rd && i_addr == OFS_PIN_RISE_EN
        |=> o_rdata[31:8] == 24'h0) else $error("rising enable reserved set");
    AST_TIMER_IRQ: assert property (i_frame_timer_evt && i_main_irq_en[29]
        && $past(i_main_irq_en[29]) && !$past(i_rst) |=> o_irq) else $error("timer irq");
    AST_TRIG_IRQ: assert property (i_frame_trigger_evt && i_main_irq_en[28]
        && $past(i_main_irq_en[28]) && !$past(i_rst) |=> o_irq) else $error("trigger irq");
    AST_ERR_IRQ: assert property (i_err_irq_status != 32'h0 |=> o_irq)
        else $error("error summary irq");
    AST_STATUS_IRQ: assert property (o_rvalid && $past(i_addr) == OFS_MAIN_IRQ_STATUS
        && !$past(i_ack_on_read) && !$past(i_wr) && o_rdata != 32'h0 |-> o_irq)
        else $error("status set without irq");
endmodule
bind board_irq_status_and_edge_enable irq_props irq_props_i (.i_clk(i_clk), .i_rst(i_rst),
    .i_rd(i_rd), .i_wr(i_wr), .i_ack_on_read(i_ack_on_read), .o_rvalid(o_rvalid),
    .o_irq(o_irq), .i_frame_timer_evt(i_frame_timer_evt), .i_addr(i_addr),
    .i_frame_trigger_evt(i_frame_trigger_evt), .o_rdata(o_rdata),
    .i_main_irq_en(i_main_irq_en), .i_err_irq_status(i_err_irq_status));
`default_nettype wire

/* File: tb/host_bfm.sv */
`timescale 1ns/100ps
`default_nettype none
module host_bfm
    import irq_status_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rvalid,
    input wire logic [irq_status_pkg::DATA_W-1:0] i_rdata,
    output logic o_wr,
    output logic o_rd,
    output logic [irq_status_pkg::ADDR_W-1:0] o_addr,
    output logic [irq_status_pkg::DATA_W-1:0] o_wdata
);
    initial begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = 12'h000;
        o_wdata = 32'h0000_0000;
    end
    // acknowledge by status write, never by disabling
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(negedge i_clk);
        o_addr = a;
        o_wdata = d;
        o_wr = 1'b1;
        @(negedge i_clk);
        o_wr = 1'b0;
        o_wdata = ~d;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(negedge i_clk);
        o_addr = a;
        o_rd = 1'b1;
        @(negedge i_clk);
        o_rd = 1'b0;
        d = i_rvalid ? i_rdata : 32'hxxxx_xxxx;
    endtask
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import irq_status_pkg::*;
    logic clk, rst, wr, rd, rvalid, irq, ack_rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, en, err, got;
    logic [PIN_N-1:0] pin;
    logic [15:0] evt;
    int err_total, checked;
    int pos[16] = '{29, 28, 24, 25, 26, 27, 16, 17, 12, 12, 8, 9, 10, 4, 4, 0};
    board_irq_status_and_edge_enable board_irq_status_and_edge_enable_i (
        .i_clk(clk), .i_rst(rst), .i_addr(addr), .i_wr(wr), .i_rd(rd), .i_wdata(wdata),
        .o_rdata(rdata), .o_rvalid(rvalid), .i_ack_on_read(ack_rd), .i_main_irq_en(en),
        .i_err_irq_status(err), .i_pin(pin), .i_frame_timer_evt(evt[0]),
        .i_frame_trigger_evt(evt[1]), .i_input_conv_done(evt[5:2]),
        .i_output_conv_done(evt[7:6]), .i_in_seq_done(evt[8]), .i_in_seq_err(evt[9]),
        .i_in_seq_buf_term(evt[12:10]), .i_out_seq_done(evt[13]),
        .i_out_seq_err(evt[14]), .i_out_seq_buf_done(evt[15]), .o_irq(irq));
    host_bfm host_bfm_i (.i_clk(clk), .i_rvalid(rvalid), .i_rdata(rdata), .o_wr(wr),
        .o_rd(rd), .o_addr(addr), .o_wdata(wdata));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic chk(input string n, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        host_bfm_i.rd(a, got);
        chk("rdata", e, got);
    endtask
    task automatic pulse(input int k);
        @(negedge clk);
        evt = 16'h0001 << k;
        @(negedge clk);
        evt = 16'h0000;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        rst = 1'b1;
        ack_rd = 1'b0;
        en = ZERO_WORD;
        err = ZERO_WORD;
        pin = 8'hff;
        evt = 16'h0000;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        rc(OFS_PIN_FALL_EN, ZERO_WORD);
        rc(OFS_PIN_RISE_EN, ZERO_WORD);
        rc(12'h000, ZERO_WORD);
        host_bfm_i.wr(OFS_PIN_FALL_EN, 32'hffff_ffa5);
        host_bfm_i.wr(OFS_PIN_RISE_EN, 32'hffff_ff5a);
        rc(OFS_PIN_FALL_EN, 32'h0000_00a5);
        rc(OFS_PIN_RISE_EN, 32'h0000_005a);
        pulse(0);
        rc(OFS_MAIN_IRQ_STATUS, ZERO_WORD);
        en = MAIN_RC_MASK;
        for (int k = 0; k < 16; k++) begin
            pulse(k);
            rc(OFS_MAIN_IRQ_STATUS, 32'h1 << pos[k]);
            chk("irq", 32'h1, 32'(irq));
            host_bfm_i.wr(OFS_MAIN_IRQ_STATUS, 32'h1 << pos[k]);
            rc(OFS_MAIN_IRQ_STATUS, ZERO_WORD);
            chk("irq", ZERO_WORD, 32'(irq));
        end
        pulse(0);
        en = ZERO_WORD;
        rc(OFS_MAIN_IRQ_STATUS, 32'h2000_0000);
        host_bfm_i.wr(OFS_MAIN_IRQ_STATUS, MAIN_RC_MASK);
        en = MAIN_RC_MASK;
        ack_rd = 1'b1;
        pulse(1);
        host_bfm_i.wr(OFS_MAIN_IRQ_STATUS, MAIN_RC_MASK);
        rc(OFS_MAIN_IRQ_STATUS, 32'h1000_0000);
        rc(OFS_MAIN_IRQ_STATUS, ZERO_WORD);
        ack_rd = 1'b0;
        err = 32'h0001_0000;
        host_bfm_i.wr(OFS_MAIN_IRQ_STATUS, 32'hffff_ffff);
        rc(OFS_MAIN_IRQ_STATUS, 32'h4000_0000);
        chk("irq", 32'h1, 32'(irq));
        err = ZERO_WORD;
        pin = 8'h00;
        rc(OFS_PIN_IRQ_STATUS, 32'h0000_a500);
        chk("irq", 32'h1, 32'(irq));
        host_bfm_i.wr(OFS_MAIN_IRQ_STATUS, 32'hffff_ffff);
        rc(OFS_MAIN_IRQ_STATUS, 32'h8000_0000);
        host_bfm_i.wr(OFS_PIN_IRQ_STATUS, 32'h0000_ffff);
        pin = 8'hff;
        rc(OFS_PIN_IRQ_STATUS, 32'h0000_005a);
        tally_and_finish();
    end
    initial begin
        #100000;
        err_total++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
